// File: ccm_star_formatter.sv
// Overview of operation
// - non-command frame passes key usage when any valid entry's frame type matches.
// - command frame passes only when an entry matches frame type and command id.
// - no matching entry after the whole list gives a failed key usage status.
// - nonce is thirteen octets: 8 source address, 4 frame counter, 1 level.
// - first nonce field occupies the leftmost octets, level the rightmost octet.
// - nonce uses originator extended address, header frame counter, frame level.
// - tag length for both directions comes from the security level subfield.
// - tag length 0,4,8,16 octets for levels 0/4, 1/5, 2/6, 3/7.
// - securing routes header, open and private payload to a or m by level.
// - c is the code, encrypted payload, or encrypted payload then code.
// - secure without confidentiality appends c; with confidentiality c replaces payload.
// - unsecuring takes trailing code or encrypted payload as c, rest as a.
// - unsecure restores m with confidentiality, else strips trailing c from payload.
// - secure uses encrypt-and-authenticate, unsecure uses decrypt-and-check.
// - auxiliary header expected or produced only when security enabled bit set.
// - auxiliary header is control octet, 4-octet counter, 0/1/5/9-octet key id.
// - control octet: level bits 0-2, key id mode bits 3-4, reserved 5-7.
// - key id length 0, 1, 5, 9 octets for modes 0 to 3.
`timescale 1ns/1ps
`include "ccm_fmt_params.svh"

module ccm_star_formatter #(
   parameter int KU_MAX   = 8,
   parameter int LEN_BITS = 16
) (
   input  wire logic                                 i_clk,
   input  wire logic                                 i_rst,
   input  wire logic                                 i_ku_start,
   input  wire logic [2:0]                           i_ku_frame_type,
   input  wire logic [7:0]                           i_ku_cmd_id,
   input  wire ccm_fmt_pkg::ku_entry_t [KU_MAX-1:0]  i_ku_list,
   output logic                                      o_ku_done,
   output logic                                      o_ku_pass,
   input  wire logic                                 i_start,
   input  wire logic                                 i_unsecure,
   input  wire logic                                 i_sec_enabled,
   input  wire logic [2:0]                           i_sec_level,
   input  wire logic [63:0]                          i_ext_addr,
   input  wire logic [LEN_BITS-1:0]                  i_priv_len,
   input  wire ccm_fmt_pkg::octet_t                  i_in,
   output logic                                      o_core_decrypt,
   output logic [4:0]                                o_tag_len,
   output logic [8*`NONCE_OCTETS-1:0]                o_nonce,
   output logic                                      o_nonce_valid,
   output ccm_fmt_pkg::out_octet_t                   o_a,
   output ccm_fmt_pkg::out_octet_t                   o_m,
   output ccm_fmt_pkg::out_octet_t                   o_c,
   input  wire ccm_fmt_pkg::out_octet_t              i_core,
   input  wire logic                                 i_core_done,
   input  wire logic                                 i_core_ok,
   output ccm_fmt_pkg::out_octet_t                   o_pay,
   output logic                                      o_fmt_err,
   output logic                                      o_done,
   output logic                                      o_pass
);

   if (KU_MAX < 1 || KU_MAX > 256 || LEN_BITS < 5) begin : g_bad_params
      $error("ccm_star_formatter: unsupported parameter values");
   end
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT_CORE} state_t;
   function automatic logic [4:0] tag_len(input logic [2:0] lvl);
      unique case (lvl[1:0])
         2'h0:    tag_len = `TAG_LEN_MIC0;
         2'h1:    tag_len = `TAG_LEN_MIC32;
         2'h2:    tag_len = `TAG_LEN_MIC64;
         2'h3:    tag_len = `TAG_LEN_MIC128;
      endcase
   endfunction : tag_len
   function automatic logic [3:0] kid_len(input logic [1:0] mode);
      unique case (mode)
         2'h0:    kid_len = `KID_LEN_MODE0;
         2'h1:    kid_len = `KID_LEN_MODE1;
         2'h2:    kid_len = `KID_LEN_MODE2;
         2'h3:    kid_len = `KID_LEN_MODE3;
      endcase
   endfunction : kid_len
   // key usage scan, one entry per cycle
   logic                      ku_busy_reg;
   logic [$clog2(KU_MAX+1)-1:0] ku_idx_reg;
   logic [2:0]                ku_type_reg;
   logic [7:0]                ku_cmd_reg;
   ccm_fmt_pkg::ku_entry_t    ku_cur;
   logic                      ku_hit;
   assign ku_cur = i_ku_list[ku_idx_reg[$clog2(KU_MAX+1)-1:0] % KU_MAX];
   assign ku_hit = ku_cur.valid && ku_cur.frame_type == ku_type_reg &&
                   (ku_type_reg != `FRAME_TYPE_CMD || ku_cur.cmd_id == ku_cmd_reg);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ku_busy_reg <= 1'b0;
         ku_idx_reg  <= '0;
         ku_type_reg <= 3'h0;
         ku_cmd_reg  <= 8'h00;
         o_ku_done   <= 1'b0;
         o_ku_pass   <= 1'b0;
      end else begin
         o_ku_done <= 1'b0;
         if (i_ku_start && !ku_busy_reg) begin
            ku_busy_reg <= 1'b1;
            ku_idx_reg  <= '0;
            ku_type_reg <= i_ku_frame_type;
            ku_cmd_reg  <= i_ku_cmd_id;
         end else if (ku_busy_reg) begin
            if (ku_hit) begin
               ku_busy_reg <= 1'b0;
               o_ku_done   <= 1'b1;
               o_ku_pass   <= 1'b1;
            end else if (ku_idx_reg == ($clog2(KU_MAX+1))'(KU_MAX - 1)) begin
               ku_busy_reg <= 1'b0;
               o_ku_done   <= 1'b1;
               o_ku_pass   <= 1'b0;
            end else begin
               ku_idx_reg <= ku_idx_reg + 1'b1;
            end
         end
      end
   end
   // frame parse and routing
   state_t              state_reg;
   logic [2:0]          level_reg;
   logic                unsec_reg;
   logic                secen_reg;
   logic [LEN_BITS-1:0] priv_len_reg;
   logic [3:0]          aux_idx_reg;
   logic [3:0]          aux_need_reg;
   logic [31:0]         fc_reg;
   logic [LEN_BITS-1:0] priv_idx_reg;
   logic                err_reg;
   logic                conf;
   logic                auth;
   logic                in_tail;
   logic                aux_bad;
   logic                lvl_bad;
   logic                end_bad;
   logic [3:0]          kid_now;
   assign conf    = level_reg[`SC_CONF_BIT];
   assign auth    = tag_len(level_reg) != `TAG_LEN_MIC0;
   assign in_tail = priv_idx_reg >= priv_len_reg - LEN_BITS'(tag_len(level_reg));
   assign kid_now = kid_len(i_in.data[`SC_KIDMODE_MSB:`SC_KIDMODE_LSB]);
   // aux octets only legal with the enabled bit, and no more than the layout holds
   assign aux_bad = i_in.seg == ccm_fmt_pkg::SEG_AUX &&
                    (!secen_reg || (aux_idx_reg != `AUX_CTRL_IDX && aux_idx_reg >= aux_need_reg));
   // level announced at start must match the parsed control octet
   assign lvl_bad = i_in.seg == ccm_fmt_pkg::SEG_AUX && aux_idx_reg == `AUX_CTRL_IDX &&
                    i_in.data[`SC_LEVEL_MSB:`SC_LEVEL_LSB] != level_reg;
   assign end_bad = secen_reg && aux_idx_reg != aux_need_reg;
   assign o_tag_len      = tag_len(level_reg);
   assign o_core_decrypt = unsec_reg;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg    <= ST_IDLE;
         level_reg    <= 3'h0;
         unsec_reg    <= 1'b0;
         secen_reg    <= 1'b0;
         priv_len_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (i_start) begin
                  state_reg    <= ST_RUN;
                  level_reg    <= i_sec_enabled ? i_sec_level : 3'h0;
                  unsec_reg    <= i_unsecure;
                  secen_reg    <= i_sec_enabled;
                  priv_len_reg <= i_priv_len;
               end
            end
            ST_RUN: begin
               if (i_in.valid && i_in.last) begin
                  // level 0 or a malformed header ends at the last octet without waiting for the core
                  state_reg <= (level_reg == 3'h0 || err_reg || aux_bad || lvl_bad || end_bad) ?
                               ST_IDLE : ST_WAIT_CORE;
               end
            end
            ST_WAIT_CORE: begin
               if (i_core_done) begin
                  state_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         aux_idx_reg  <= 4'h0;
         aux_need_reg <= 4'h0;
         fc_reg       <= 32'h0;
         priv_idx_reg <= '0;
         err_reg      <= 1'b0;
      end else if (state_reg == ST_IDLE) begin
         aux_idx_reg  <= 4'h0;
         aux_need_reg <= `AUX_FIXED_OCTETS;
         priv_idx_reg <= '0;
         err_reg      <= 1'b0;
      end else if (state_reg == ST_RUN && i_in.valid) begin
         if (aux_bad || lvl_bad) begin
            err_reg <= 1'b1;
         end
         if (i_in.seg == ccm_fmt_pkg::SEG_AUX) begin
            aux_idx_reg <= aux_idx_reg + 4'h1;
            if (aux_idx_reg == `AUX_CTRL_IDX) begin
               aux_need_reg <= `AUX_FIXED_OCTETS + kid_now;
            end
            if (aux_idx_reg != `AUX_CTRL_IDX && aux_idx_reg <= `AUX_FC_LAST_IDX) begin
               fc_reg <= {i_in.data, fc_reg[31:8]};  // counter arrives low octet first
            end
         end
         if (i_in.seg == ccm_fmt_pkg::SEG_PRIV) begin
            priv_idx_reg <= priv_idx_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_nonce       <= '0;
         o_nonce_valid <= 1'b0;
      end else if (state_reg == ST_IDLE) begin
         o_nonce_valid <= 1'b0;
      end else if (secen_reg && !o_nonce_valid && aux_idx_reg == aux_need_reg) begin
         o_nonce       <= {i_ext_addr, fc_reg, 5'h00, level_reg};
         o_nonce_valid <= 1'b1;
      end
   end

   // octet steering toward the core, one cycle behind the input
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_a <= '0;
         o_m <= '0;
         o_c <= '0;
      end else begin
         o_a.valid <= 1'b0;
         o_m.valid <= 1'b0;
         o_c.valid <= 1'b0;
         o_a.data  <= i_in.data;
         o_m.data  <= i_in.data;
         o_c.data  <= i_in.data;
         if (state_reg == ST_RUN && i_in.valid && level_reg != 3'h0) begin
            unique case (i_in.seg)
               ccm_fmt_pkg::SEG_MHR, ccm_fmt_pkg::SEG_AUX,
               ccm_fmt_pkg::SEG_OPEN: o_a.valid <= auth || (conf && unsec_reg);
               ccm_fmt_pkg::SEG_PRIV: begin
                  if (!unsec_reg) begin
                     o_m.valid <= conf;
                     o_a.valid <= !conf && auth;
                  end else begin
                     o_c.valid <= conf || in_tail;
                     o_a.valid <= !conf && !in_tail;
                  end
               end
            endcase
         end
      end
   end

   // rebuilt private payload: own octets, then or instead the core output
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pay <= '0;
      end else begin
         o_pay.valid <= 1'b0;
         if (state_reg == ST_RUN && i_in.valid && i_in.seg == ccm_fmt_pkg::SEG_PRIV &&
             (level_reg == 3'h0 || (!conf && (!unsec_reg || !in_tail)))) begin
            o_pay.valid <= 1'b1;
            o_pay.data  <= i_in.data;
         end else if (state_reg != ST_IDLE && i_core.valid && (!unsec_reg || conf)) begin
            o_pay.valid <= 1'b1;
            o_pay.data  <= i_core.data;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_done    <= 1'b0;
         o_pass    <= 1'b0;
         o_fmt_err <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (state_reg == ST_RUN && i_in.valid && i_in.last) begin
            o_fmt_err <= err_reg || aux_bad || lvl_bad || end_bad;
            if (level_reg == 3'h0 || err_reg || aux_bad || lvl_bad || end_bad) begin
               o_done <= 1'b1;
               o_pass <= !(err_reg || aux_bad || lvl_bad || end_bad);
            end
         end else if (state_reg == ST_WAIT_CORE && i_core_done) begin
            o_done <= 1'b1;
            o_pass <= i_core_ok;
         end
      end
   end

endmodule : ccm_star_formatter

// File: ccm_fmt_params.svh
`ifndef CCM_FMT_PARAMS_SVH
`define CCM_FMT_PARAMS_SVH

`define FRAME_TYPE_CMD    3'h3
`define NONCE_OCTETS      13
`define NONCE_ADDR_OCTETS 8
`define NONCE_FC_OCTETS   4
`define AUX_CTRL_IDX      4'h0
`define AUX_FC_LAST_IDX   4'h4
`define AUX_FIXED_OCTETS  4'h5
`define SC_LEVEL_LSB      0
`define SC_LEVEL_MSB      2
`define SC_KIDMODE_LSB    3
`define SC_KIDMODE_MSB    4
`define SC_CONF_BIT       2
`define KID_LEN_MODE0     4'h0
`define KID_LEN_MODE1     4'h1
`define KID_LEN_MODE2     4'h5
`define KID_LEN_MODE3     4'h9
`define TAG_LEN_MIC0      5'h00
`define TAG_LEN_MIC32     5'h04
`define TAG_LEN_MIC64     5'h08
`define TAG_LEN_MIC128    5'h10

`endif

// File: ccm_fmt_pkg.sv
package ccm_fmt_pkg;

   typedef enum logic [1:0] {
      SEG_MHR,
      SEG_AUX,
      SEG_OPEN,
      SEG_PRIV
   } seg_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] frame_type;
      logic [7:0] cmd_id;
   } ku_entry_t;

   typedef struct packed {
      logic       valid;
      logic       last;
      seg_t       seg;
      logic [7:0] data;
   } octet_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } out_octet_t;

endpackage : ccm_fmt_pkg

// File: ccm_star_formatter_properties.sv
`timescale 1ns/1ps
module ccm_fmt_checker (
   input wire logic                    i_clk,
   input wire logic                    i_rst,
   input wire logic [63:0]             i_ext_addr,
   input wire ccm_fmt_pkg::octet_t     i_in,
   input wire logic [4:0]              o_tag_len,
   input wire logic [103:0]            o_nonce,
   input wire logic                    o_nonce_valid,
   input wire ccm_fmt_pkg::out_octet_t o_a,
   input wire ccm_fmt_pkg::out_octet_t o_m,
   input wire ccm_fmt_pkg::out_octet_t o_c,
   input wire logic                    i_core_done,
   input wire logic                    i_core_ok,
   input wire logic                    o_done,
   input wire logic                    o_pass
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_nonce_addr; o_nonce_valid |-> o_nonce[103:40] == i_ext_addr; endproperty
   a_nonce_addr: assert property (p_nonce_addr) else $error("nonce address field wrong");
   property p_nonce_lvl; o_nonce_valid |-> o_nonce[7:3] == 5'h00; endproperty
   a_nonce_lvl: assert property (p_nonce_lvl) else $error("nonce level octet wrong");
   property p_tag; o_nonce_valid |-> o_tag_len == (o_nonce[1:0] == 2'h0 ? 5'h00 : 5'h02 << o_nonce[1:0]);
   endproperty
   a_tag: assert property (p_tag) else $error("tag length does not follow level");
   property p_m_priv;
      o_m.valid |-> $past(i_in.seg) == ccm_fmt_pkg::SEG_PRIV && o_m.data == $past(i_in.data);
   endproperty
   a_m_priv: assert property (p_m_priv) else $error("m octet not from private payload");
   property p_a_copy; o_a.valid |-> $past(i_in.valid) && o_a.data == $past(i_in.data); endproperty
   a_a_copy: assert property (p_a_copy) else $error("a octet not a copy of input");
   property p_c_priv;
      o_c.valid |-> $past(i_in.seg) == ccm_fmt_pkg::SEG_PRIV && o_c.data == $past(i_in.data);
   endproperty
   a_c_priv: assert property (p_c_priv) else $error("c octet not from private payload");
   property p_done; i_core_done |=> o_done && o_pass == $past(i_core_ok); endproperty
   a_done: assert property (p_done) else $error("done or pass does not follow core");
   property p_done_pulse; o_done |=> !o_done; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
   c_pass: cover property (o_done && o_pass);
   c_fail: cover property (o_done && !o_pass);
   c_m: cover property (o_m.valid);
endmodule : ccm_fmt_checker
bind ccm_star_formatter ccm_fmt_checker u_ccm_fmt_checker (.i_clk(i_clk), .i_rst(i_rst),
   .i_ext_addr(i_ext_addr), .i_in(i_in), .o_tag_len(o_tag_len), .o_nonce(o_nonce),
   .o_nonce_valid(o_nonce_valid), .o_a(o_a), .o_m(o_m), .o_c(o_c), .i_core_done(i_core_done),
   .i_core_ok(i_core_ok), .o_done(o_done), .o_pass(o_pass));

// File: ccm_core_model.sv
`timescale 1ns/1ps
// cipher stand-in: xor 5a stream, tag bytes a0 upward
module ccm_core_model (
   input  wire logic                    i_clk,
   input  wire ccm_fmt_pkg::out_octet_t i_m,
   input  wire ccm_fmt_pkg::out_octet_t i_c,
   input  wire logic                    i_decrypt,
   input  wire logic [4:0]              i_tag_len,
   input  wire logic                    i_go,
   input  wire logic [3:0]              i_delay,
   input  wire logic                    i_bad,
   output ccm_fmt_pkg::out_octet_t      o_core,
   output logic                         o_done,
   output logic                         o_ok
);
   logic [7:0] q[$];
   int n;
   always @(posedge i_clk) begin
      if (i_m.valid) q.push_back(i_m.data ^ 8'h5a);
      if (i_c.valid) q.push_back(i_c.data ^ 8'h5a);
   end
   initial begin
      o_core = '0;
      o_done = 1'b0;
      o_ok = 1'b0;
      forever begin
         @(posedge i_clk);
         if (i_go) begin
            repeat (i_delay) @(posedge i_clk);
            n = i_decrypt ? q.size() - int'(i_tag_len) : q.size();
            for (int i = 0; i < n + (i_decrypt ? 0 : int'(i_tag_len)); i++) begin
               o_core <= '{1'b1, i < n ? q[i] : 8'ha0 + 8'(i - n)};
               @(posedge i_clk);
            end
            o_core <= '{1'b0, ~o_core.data};
            o_done <= 1'b1;
            o_ok <= !i_bad;
            q.delete();
            @(posedge i_clk);
            o_done <= 1'b0;
         end
      end
   end
endmodule : ccm_core_model

// File: ccm_star_formatter_tb.sv
`timescale 1ns/1ps
module ccm_star_formatter_tb;
   localparam int KU = 4;
   logic i_clk = 1'b0, i_rst = 1'b1, ku_start = 1'b0, start = 1'b0, unsec = 1'b0, en = 1'b0;
   logic go = 1'b0, bad_tag = 1'b0, ku_done, ku_pass, core_dec, nonce_v, core_done, core_ok;
   logic fmt_err, done, pass, gp, ge, gd;
   logic [2:0] ku_type = 3'h0, lvl = 3'h0;
   logic [7:0] ku_cmd = 8'h00, fd[$], pq[$];
   logic [3:0] dly = 4'h0;
   logic [4:0] tag_len;
   logic [15:0] plen = 16'h0000;
   logic [63:0] ext = 64'h0;
   logic [103:0] nonce, gn;
   ccm_fmt_pkg::ku_entry_t [KU-1:0] ku_list = '0;
   ccm_fmt_pkg::octet_t din = '0;
   ccm_fmt_pkg::out_octet_t oa, om, oc, core, pay;
   ccm_fmt_pkg::seg_t fs[$];
   int fails = 0, comparisons = 0, na, nm, nc, got_done, got_nv;
   ccm_star_formatter #(.KU_MAX(KU), .LEN_BITS(16)) u_ccm_star_formatter (.i_clk(i_clk), .i_rst(i_rst),
      .i_ku_start(ku_start), .i_ku_frame_type(ku_type), .i_ku_cmd_id(ku_cmd), .i_ku_list(ku_list),
      .o_ku_done(ku_done), .o_ku_pass(ku_pass), .i_start(start), .i_unsecure(unsec), .i_sec_enabled(en),
      .i_sec_level(lvl), .i_ext_addr(ext), .i_priv_len(plen), .i_in(din), .o_core_decrypt(core_dec),
      .o_tag_len(tag_len), .o_nonce(nonce), .o_nonce_valid(nonce_v), .o_a(oa), .o_m(om), .o_c(oc),
      .i_core(core), .i_core_done(core_done), .i_core_ok(core_ok), .o_pay(pay), .o_fmt_err(fmt_err),
      .o_done(done), .o_pass(pass));
   ccm_core_model u_ccm_core_model (.i_clk(i_clk), .i_m(om), .i_c(oc), .i_decrypt(core_dec),
      .i_tag_len(tag_len), .i_go(go), .i_delay(dly), .i_bad(bad_tag), .o_core(core),
      .o_done(core_done), .o_ok(core_ok));
   always #12.5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      na += int'(oa.valid);
      nm += int'(om.valid);
      nc += int'(oc.valid);
      if (pay.valid) pq.push_back(pay.data);
      if (nonce_v && got_nv == 0) begin
         got_nv = 1;
         gn = nonce;
         gd = core_dec;
      end
      if (done) begin
         got_done = 1;
         gp = pass;
         ge = fmt_err;
      end
   end
   task automatic chk(string nm, logic [103:0] e, logic [103:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task automatic test_done();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   function automatic void put(ccm_fmt_pkg::seg_t s, logic [7:0] d);
      fs.push_back(s);
      fd.push_back(d);
   endfunction : put
   task automatic ku_trial();
      ccm_fmt_pkg::ku_entry_t [KU-1:0] lst;
      logic [2:0] ft;
      logic [7:0] cid;
      int hit, n;
      ft = 3'($urandom % 4);
      cid = 8'($urandom % 2);
      hit = -1;
      for (int e = KU - 1; e >= 0; e--) begin
         lst[e] = ccm_fmt_pkg::ku_entry_t'({1'($urandom), 1'b0, 2'($urandom), 7'h00, 1'($urandom)});
         if (lst[e].valid && lst[e].frame_type == ft && (ft != 3'h3 || lst[e].cmd_id == cid)) hit = e;
      end
      @(posedge i_clk);
      ku_list <= lst;
      ku_type <= ft;
      ku_cmd <= cid;
      ku_start <= 1'b1;
      @(posedge i_clk);
      ku_start <= 1'b0;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (!ku_done && n < 20);
      chk("ku latency", hit < 0 ? KU + 1 : hit + 2, n);
      chk("ku pass", hit >= 0, ku_pass);
   endtask : ku_trial
   task automatic frame(bit u, bit e, logic [2:0] l, bit bl, bit bt);
      logic [7:0] ep[$];
      logic [63:0] xa;
      logic [31:0] fc;
      logic [2:0] lv;
      logic [1:0] km;
      int pv, tl, hd;
      lv = e ? l : 3'h0;
      tl = lv[1:0] == 2'h0 ? 0 : 2 << lv[1:0];
      pv = 1 + $urandom % 5 + (u ? tl : 0);
      xa = {$urandom, $urandom};
      fc = $urandom;
      km = 2'($urandom);
      fs.delete();
      fd.delete();
      repeat (1 + $urandom % 3) put(ccm_fmt_pkg::SEG_MHR, 8'($urandom));
      if (e) begin
         put(ccm_fmt_pkg::SEG_AUX, {3'h0, km, bl ? ~lv : lv});
         for (int i = 0; i < 4; i++) put(ccm_fmt_pkg::SEG_AUX, fc[8*i +: 8]);
         repeat (km == 0 ? 0 : km == 1 ? 1 : km == 2 ? 5 : 9) put(ccm_fmt_pkg::SEG_AUX, 8'($urandom));
      end
      repeat ($urandom % 3) put(ccm_fmt_pkg::SEG_OPEN, 8'($urandom));
      hd = fd.size();
      repeat (pv) put(ccm_fmt_pkg::SEG_PRIV, 8'($urandom));
      for (int i = 0; i < pv - (u ? tl : 0); i++) ep.push_back(fd[hd + i] ^ (lv[2] ? 8'h5a : 8'h00));
      for (int i = 0; i < (u || lv == 0 ? 0 : tl); i++) ep.push_back(8'ha0 + 8'(i));
      na = 0;
      nm = 0;
      nc = 0;
      got_done = 0;
      got_nv = 0;
      pq.delete();
      @(posedge i_clk);
      start <= 1'b1;
      unsec <= u;
      en <= e;
      lvl <= l;
      ext <= xa;
      plen <= 16'(pv);
      bad_tag <= bt;
      dly <= 4'($urandom % 4);
      @(posedge i_clk);
      start <= 1'b0;
      foreach (fd[i]) begin
         din <= '{1'b1, i == fd.size() - 1, fs[i], fd[i]};
         @(posedge i_clk);
      end
      din <= '{1'b0, 1'b0, ccm_fmt_pkg::SEG_MHR, ~fd[$]};
      if (lv != 0 && !bl) begin
         @(posedge i_clk);
         go <= 1'b1;
         @(posedge i_clk);
         go <= 1'b0;
      end
      for (int n = 0; n < 300 && got_done == 0; n++) @(posedge i_clk);
      chk("done", 1, got_done);
      chk("fmt_err", bl, ge);
      chk("pass", !bl && !(bt && lv != 0), gp);
      if (!bl && !bt) begin
         chk("a count", lv == 0 || (lv == 4 && !u) ? 0 : hd + (lv[2] ? 0 : pv - (u ? tl : 0)), na);
         chk("m count", !u && lv[2] ? pv : 0, nm);
         chk("c count", u ? (lv[2] ? pv : tl) : 0, nc);
         chk("pay count", ep.size(), pq.size());
         foreach (ep[i]) chk("pay", ep[i], pq[i]);
         chk("nonce valid", e, got_nv);
         if (got_nv != 0) chk("nonce", {xa, fc, 5'h00, lv}, gn);
         if (got_nv != 0) chk("decrypt", u, gd);
      end
   endtask : frame
   initial begin
      void'($urandom(33));
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (24) ku_trial();
      $display("test key usage done");
      for (int k = 0; k < 16; k++) frame(k[3], 1'b1, k[2:0], 1'b0, 1'b0);
      $display("test levels done");
      frame(1'b0, 1'b0, 3'h5, 1'b0, 1'b0);
      frame(1'b1, 1'b0, 3'h3, 1'b0, 1'b0);
      frame(1'b0, 1'b1, 3'h6, 1'b1, 1'b0);
      frame(1'b1, 1'b1, 3'h5, 1'b0, 1'b1);
      $display("test faults done");
      test_done();
   end
   initial begin
      #(25 * 30000);
      fails++;
      test_done();
   end
endmodule : ccm_star_formatter_tb
